// File: verilog/sdcb_pkg.sv
// Purpose: shared constants for the sdram command and burst core
// Assumes: 16-bit data, four banks, 12-bit row, 8-bit column
// Notes:   mode register fields follow the address pins of the set cycle
`default_nettype none
package sdcb_pkg;
   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int ADDR_W = 12;
   localparam int COL_W  = 8;
   localparam int BANK_W = 2;
   localparam int NBANK  = 4;
   localparam int DQ_W   = 16;
   localparam int PIN_W  = 5 + BANK_W + ADDR_W + 2 + DQ_W;
   // ***************************************************************
   // mode register fields and codes
   // ***************************************************************
   localparam int BL_LSB  = 0;
   localparam int BL_MSB  = 2;
   localparam int BT_BIT  = 3;
   localparam int CL_LSB  = 4;
   localparam int CL_MSB  = 6;
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
   localparam logic [2:0] CL_2    = 3'h2;
   localparam logic [2:0] CL_3    = 3'h3;
   localparam logic [COL_W-1:0] MASK_1    = 8'h00;
   localparam logic [COL_W-1:0] MASK_2    = 8'h01;
   localparam logic [COL_W-1:0] MASK_4    = 8'h03;
   localparam logic [COL_W-1:0] MASK_8    = 8'h07;
   localparam logic [COL_W-1:0] MASK_PAGE = 8'hff;
   // ***************************************************************
   // reset values and counts
   // ***************************************************************
   localparam logic [2:0] BL_RST  = BL_1;
   localparam logic [2:0] CL_RST  = CL_3;
   localparam int         PRE_ALL_BIT   = 10;
   localparam logic [3:0] INIT_REFRESHES = 4'h8;
   typedef enum logic [2:0] {
      SDCB_UNINIT = 3'b001,
      SDCB_MODE   = 3'b010,
      SDCB_READY  = 3'b100
   } sdcb_init_t;
endpackage : sdcb_pkg
`default_nettype wire

// File: verilog/sdcb_col_gen.sv
// Purpose: column of one burst beat, sequential or interleave
// Assumes: beat index counts from zero at the burst start
// Notes:   bits above the burst mask are held from the start column
`default_nettype none
`timescale 1ns/1ps
module sdcb_col_gen
   import sdcb_pkg::*;
(
   input  wire logic [COL_W-1:0] start_col,
   input  wire logic [COL_W-1:0] beat,
   input  wire logic [COL_W-1:0] bl_mask,
   input  wire logic             interleave,
   output wire logic [COL_W-1:0] col
);
   wire logic [COL_W-1:0] seq_sum;
   wire logic [COL_W-1:0] low_bits;
   assign seq_sum  = start_col + beat;
   // no carry out of the masked bits: wrap inside the burst
   assign low_bits = interleave ? (start_col ^ beat) : seq_sum; // R22
   assign col      = (start_col & ~bl_mask) | (low_bits & bl_mask); // R22
endmodule : sdcb_col_gen
`default_nettype wire

// File: verilog/sdcb_core.sv
// Purpose: command decode and burst engine of a four-bank 16-bit sdram
// Assumes: array behind mem_* ports returns read data the cycle after mem_rd_q
// Notes:   every pin passes two flops, so all pin timing shifts uniformly
//
// Behaviour
// (R01) host waits 200 us with no_operation before precharging all banks
// (R02) host holds byte masks and clock gate high during the power-up pause
// (R03) host issues mode register set after all banks are precharged
// (R04) host issues eight auto refresh cycles around mode programming
// (R05) mode set only with banks idle and clock gate high a cycle before
// (R06) all strobes low decodes mode set; address bits load the mode
// (R07) host waits the mode set cycle delay before its next command
// (R08) bank activated first; column access after activate-to-column delay
// (R09) bank precharged before reactivation, row cycle time apart
// (R10) bank-to-bank delay between activations, max active time respected
// (R11) row high, column low is column access; write strobe picks direction
// (R12) host precharges and reactivates to reach another row
// (R13) column commands accepted every cycle, same or alternating banks
// (R14) burst type and length come from the mode register
// (R15) write data with command and each later edge; extra data ignored
// (R16) read interrupting read restarts a full burst at new address
// (R17) host masks bytes on first two write cycles after a read; bench masks the two cycles before the write
// (R18) write interrupting write restarts a full burst at new address
// (R19) read ends write burst at once; leftover write data dropped
// (R20) burst stop ends burst, bank stays open; full page only; core stops a burst of any length
// (R21) after burst stop, read outputs float after the column latency
// (R22) sequential columns wrap within burst bits, no carry upward
// (R23) byte mask floats read data two cycles later, blocks write at once
// (R24) chip select high ignores commands, running burst continues
`default_nettype none
`timescale 1ns/1ps
module sdcb_core
   import sdcb_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              cs_n,
   input  wire logic              row_strobe_n,
   input  wire logic              col_strobe_n,
   input  wire logic              write_strobe_n,
   input  wire logic              clk_gate,
   input  wire logic [BANK_W-1:0] bank_select,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              low_byte_mask,
   input  wire logic              high_byte_mask,
   input  wire logic [DQ_W-1:0]   dq_in,
   output logic      [DQ_W-1:0]   dq_out_q,
   output logic                   dq_oe_lo_q,
   output logic                   dq_oe_hi_q,
   input  wire logic [DQ_W-1:0]   mem_rdata,
   output logic                   mem_rd_q,
   output logic                   mem_wr_q,
   output logic      [BANK_W-1:0] mem_bank_q,
   output logic      [ADDR_W-1:0] mem_row_q,
   output logic      [COL_W-1:0]  mem_col_q,
   output logic      [DQ_W-1:0]   mem_wdata_q,
   output logic      [1:0]        mem_wbe_q,
   output logic      [2:0]        burst_len_code_q,
   output logic                   interleave_q,
   output logic      [2:0]        cas_lat_q,
   output logic      [NBANK-1:0]  bank_open_q,
   output logic                   init_done_q
);
   // ***************************************************************
   // reset release and pin synchronisers
   // ***************************************************************
   logic             rst_s1_q;
   logic             rst_n;
   logic [PIN_W-1:0] pin_s1_q;
   logic [PIN_W-1:0] pin_s2_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   wire logic [PIN_W-1:0] pin_raw;
   assign pin_raw = {cs_n, row_strobe_n, col_strobe_n, write_strobe_n, clk_gate,
                     bank_select, addr, high_byte_mask, low_byte_mask, dq_in};

   // idle-high reset value keeps the decoder seeing deselect
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= '1;
         pin_s2_q <= '1;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
      end
   end

   wire logic              cs_s, ras_s, cas_s, we_s, cke_s, mlo_s, mhi_s;
   wire logic [BANK_W-1:0] bank_s;
   wire logic [ADDR_W-1:0] addr_s;
   wire logic [DQ_W-1:0]   dq_s;
   assign {cs_s, ras_s, cas_s, we_s, cke_s, bank_s, addr_s, mhi_s, mlo_s, dq_s} = pin_s2_q;

   // ***************************************************************
   // command decode
   // ***************************************************************
   logic cke_prev_q;
   wire logic cmd_ok, cmd_mrs, cmd_act, cmd_pre, cmd_ref, cmd_rd, cmd_wr, cmd_stop;
   assign cmd_ok   = !cs_s && cke_prev_q;                  // R24
   assign cmd_mrs  = cmd_ok && !ras_s && !cas_s && !we_s;  // R06
   assign cmd_act  = cmd_ok && !ras_s &&  cas_s &&  we_s;
   assign cmd_pre  = cmd_ok && !ras_s &&  cas_s && !we_s;
   assign cmd_ref  = cmd_ok && !ras_s && !cas_s &&  we_s;
   assign cmd_rd   = cmd_ok &&  ras_s && !cas_s &&  we_s;  // R11
   assign cmd_wr   = cmd_ok &&  ras_s && !cas_s && !we_s;  // R11
   assign cmd_stop = cmd_ok &&  ras_s &&  cas_s && !we_s;  // R20

   // ***************************************************************
   // bank rows, mode register, init tracking
   // ***************************************************************
   logic [ADDR_W-1:0] row_q [NBANK];
   logic [3:0]        ref_cnt_q;
   sdcb_init_t        init_q;

   wire logic rw_now;
   assign rw_now = (cmd_rd || cmd_wr) && bank_open_q[bank_s]; // R13

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_open_q <= '0;
         for (int i = 0; i < NBANK; i++) begin
            row_q[i] <= '0;
         end
      end else if (cmd_act) begin
         bank_open_q[bank_s] <= 1'b1;
         row_q[bank_s]       <= addr_s;
      end else if (cmd_pre) begin
         if (addr_s[PRE_ALL_BIT]) begin
            bank_open_q <= '0;
         end else begin
            bank_open_q[bank_s] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cke_prev_q       <= 1'b0;
         burst_len_code_q <= BL_RST;
         interleave_q     <= 1'b0;
         cas_lat_q        <= CL_RST;
         ref_cnt_q        <= '0;
         init_q           <= SDCB_UNINIT;
         init_done_q      <= 1'b0;
      end else begin
         cke_prev_q <= cke_s;
         if (cmd_mrs) begin
            burst_len_code_q <= addr_s[BL_MSB:BL_LSB]; // R06
            interleave_q     <= addr_s[BT_BIT];        // R14
            cas_lat_q        <= addr_s[CL_MSB:CL_LSB]; // R06
         end
         if (cmd_ref && ref_cnt_q != INIT_REFRESHES) begin
            ref_cnt_q <= ref_cnt_q + 4'h1;
         end
         case (init_q)
            SDCB_UNINIT: if (cmd_mrs) init_q <= SDCB_MODE;
            SDCB_MODE:   if (ref_cnt_q == INIT_REFRESHES) init_q <= SDCB_READY;
            SDCB_READY:  init_q <= SDCB_READY;
            default:     init_q <= SDCB_UNINIT;
         endcase
         init_done_q <= (init_q == SDCB_READY);
      end
   end

   // ***************************************************************
   // burst engine
   // ***************************************************************
   logic              burst_q;
   logic              bwr_q;
   logic [BANK_W-1:0] bbank_q;
   logic [COL_W-1:0]  bstart_q;
   logic [COL_W-1:0]  beat_q;

   wire logic [COL_W-1:0] bl_mask;
   assign bl_mask = (burst_len_code_q == BL_2)    ? MASK_2 :
                    (burst_len_code_q == BL_4)    ? MASK_4 :
                    (burst_len_code_q == BL_8)    ? MASK_8 :
                    (burst_len_code_q == BL_PAGE) ? MASK_PAGE : MASK_1; // R14
   wire logic is_page;
   assign is_page = (burst_len_code_q == BL_PAGE);

   // a new column command overrides the rest of any running burst
   wire logic              beat_en, beat_wr, last_beat;
   wire logic [BANK_W-1:0] beat_bank;
   wire logic [COL_W-1:0]  beat_idx, beat_start, beat_col;
   assign beat_en    = rw_now || (burst_q && !cmd_stop);                      // R20
   assign beat_wr    = rw_now ? cmd_wr : bwr_q;                               // R19
   assign beat_bank  = rw_now ? bank_s : bbank_q;
   assign beat_start = rw_now ? addr_s[COL_W-1:0] : bstart_q;                 // R16
   assign beat_idx   = rw_now ? '0 : beat_q;                                  // R18
   assign last_beat  = !is_page && (beat_idx == bl_mask);                     // R15

   sdcb_col_gen u_col (
      .start_col  (beat_start),
      .beat       (beat_idx),
      .bl_mask    (bl_mask),
      .interleave (interleave_q),
      .col        (beat_col)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_q  <= 1'b0;
         bwr_q    <= 1'b0;
         bbank_q  <= '0;
         bstart_q <= '0;
         beat_q   <= '0;
      end else begin
         burst_q  <= beat_en && !last_beat;
         bwr_q    <= beat_wr;
         bbank_q  <= beat_bank;
         bstart_q <= beat_start;
         beat_q   <= beat_idx + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rd_q    <= 1'b0;
         mem_wr_q    <= 1'b0;
         mem_bank_q  <= '0;
         mem_row_q   <= '0;
         mem_col_q   <= '0;
         mem_wdata_q <= '0;
         mem_wbe_q   <= '0;
      end else begin
         mem_rd_q    <= beat_en && !beat_wr;
         mem_wr_q    <= beat_en && beat_wr;           // R15
         mem_bank_q  <= beat_bank;
         mem_row_q   <= row_q[beat_bank];
         mem_col_q   <= beat_col;
         mem_wdata_q <= dq_s;                         // R15
         mem_wbe_q   <= {!mhi_s, !mlo_s};             // R23
      end
   end

   // ***************************************************************
   // read data path with column latency and byte masks
   // ***************************************************************
   // latency other than two runs as three: only those two are supported
   logic                 rv1_q;
   logic [DQ_W:0]        st1_q;
   logic [DQ_W:0]        st2_q;
   logic [1:0]           mk1_q;
   logic [1:0]           mk2_q;
   logic [1:0]           mk3_q;

   wire logic [DQ_W:0] cap, sel;
   assign cap = {rv1_q, mem_rdata};
   assign sel = (cas_lat_q == CL_2) ? st1_q : st2_q; // R16

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rv1_q      <= 1'b0;
         st1_q      <= '0;
         st2_q      <= '0;
         mk1_q      <= '0;
         mk2_q      <= '0;
         mk3_q      <= '0;
         dq_out_q   <= '0;
         dq_oe_lo_q <= 1'b0;
         dq_oe_hi_q <= 1'b0;
      end else begin
         rv1_q      <= mem_rd_q;
         st1_q      <= cap;
         st2_q      <= st1_q;                         // R21
         mk1_q      <= {mhi_s, mlo_s};
         mk2_q      <= mk1_q;
         mk3_q      <= mk2_q;
         dq_out_q   <= sel[DQ_W-1:0];
         dq_oe_lo_q <= sel[DQ_W] && !mk3_q[0];        // R23
         dq_oe_hi_q <= sel[DQ_W] && !mk3_q[1];        // R23
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_mode_load: assert property (cmd_mrs |=> burst_len_code_q == $past(addr_s[BL_MSB:BL_LSB])
      && cas_lat_q == $past(addr_s[CL_MSB:CL_LSB])) else $error("mode not loaded"); // R06
   a_read_issue: assert property (cmd_rd && bank_open_q[bank_s] |=> mem_rd_q && !mem_wr_q
      && mem_col_q[BL_LSB] == $past(addr_s[BL_LSB])) else $error("read not issued"); // R11
   a_back_back: assert property (rw_now ##1 rw_now |=> (mem_rd_q || mem_wr_q)
      && mem_bank_q == $past(bank_s)) else $error("back to back lost"); // R13
   a_len_four: assert property (rw_now && burst_len_code_q == BL_4
      ##1 (!rw_now && !cmd_stop)[*3] |=> !burst_q) else $error("burst length wrong"); // R14
   a_write_data: assert property (cmd_wr && bank_open_q[bank_s] |=> mem_wr_q
      && mem_wdata_q == $past(dq_s)) else $error("write data lost"); // R15
   a_read_cuts: assert property (burst_q && bwr_q && rw_now && cmd_rd |=> mem_rd_q
      && !mem_wr_q && mem_col_q == $past(addr_s[COL_W-1:0])) else $error("read no cut"); // R19
   a_stop_ends: assert property (cmd_stop && !rw_now |=> !burst_q && !mem_rd_q
      && !mem_wr_q) else $error("stop ignored"); // R20
   a_stop_float: assert property (cmd_stop ##1 (!beat_en)[*5]
      |-> !dq_oe_lo_q && !dq_oe_hi_q) else $error("outputs not floated"); // R21
   a_seq_wrap: assert property (beat_en && !interleave_q && burst_len_code_q == BL_4
      |=> mem_col_q[COL_W-1:2] == $past(beat_start[COL_W-1:2])) else $error("carry out"); // R22
   a_mask_write: assert property (beat_en && beat_wr && (mlo_s || mhi_s) |=>
      mem_wbe_q[0] == !$past(mlo_s) && mem_wbe_q[1] == !$past(mhi_s))
      else $error("masked byte written"); // R23
   a_deselect: assert property (cs_s && !burst_q |=> !mem_rd_q && !mem_wr_q)
      else $error("deselect not ignored"); // R24

   c_read: cover property (cmd_rd && bank_open_q[bank_s] ##[1:8] dq_oe_lo_q);
   c_rd_rd: cover property (burst_q && !bwr_q && cmd_rd && bank_open_q[bank_s]);
   c_stop: cover property (burst_q && cmd_stop && is_page);
   c_init: cover property (init_done_q);
endmodule : sdcb_core
`default_nettype wire

// File: testbench/sdcb_host_model.sv
// Purpose: host controller model driving the sdram command pins
// Assumes: one command per call, pins change 1 ns after the rising edge
// Notes:   spacing gaps are plain parameters, no real part timing behind them
`timescale 1ns/1ps
`default_nettype none
module sdcb_host_model
   import sdcb_pkg::*;
#(
   parameter int T_PAUSE = 50000,
   parameter int T_GAP   = 4
)(
   input  wire logic              core_clk,
   output logic                   cs_n,
   output logic                   row_strobe_n,
   output logic                   col_strobe_n,
   output logic                   write_strobe_n,
   output logic                   clk_gate,
   output logic      [BANK_W-1:0] bank_select,
   output logic      [ADDR_W-1:0] addr,
   output logic                   low_byte_mask,
   output logic                   high_byte_mask,
   output logic      [DQ_W-1:0]   dq_in
);
   initial begin
      {cs_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'hf;
      clk_gate = 1'b1;
      bank_select = 2'h0;
      addr = 12'h000;
      {high_byte_mask, low_byte_mask} = 2'h3;
      dq_in = 16'h0000;
   end
   // ***************************************************************
   // command tasks
   // ***************************************************************
   task automatic cmd(input logic [3:0] c, input logic [BANK_W-1:0] b,
                      input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d,
                      input logic [1:0] m);
      @(posedge core_clk);
      #1;
      {cs_n, row_strobe_n, col_strobe_n, write_strobe_n} = c;
      bank_select = b;
      addr = a;
      dq_in = d;
      {high_byte_mask, low_byte_mask} = m;
   endtask : cmd
   // idle bus shows the inverse of its last value, never a stale copy
   task automatic idle(input int n);
      for (int i = 0; i < n; i++) cmd(4'h7, ~bank_select, ~addr, ~dq_in, 2'h0);
   endtask : idle
   task automatic set_mode(input logic [ADDR_W-1:0] mode);
      cmd(4'h2, 2'h0, 12'h400, ~dq_in, 2'h0);
      idle(T_GAP);
      cmd(4'h0, 2'h0, mode, ~dq_in, 2'h0);
      idle(T_GAP);
   endtask : set_mode
   task automatic activate(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] r);
      cmd(4'h3, b, r, ~dq_in, 2'h0);
      idle(T_GAP);
   endtask : activate
   // clock gate low one cycle, then a command that must be dropped
   task automatic gated(input logic [3:0] c, input logic [BANK_W-1:0] b,
                        input logic [ADDR_W-1:0] a);
      @(posedge core_clk);
      #1;
      clk_gate = 1'b0;
      @(posedge core_clk);
      #1;
      clk_gate = 1'b1;
      {cs_n, row_strobe_n, col_strobe_n, write_strobe_n} = c;
      bank_select = b;
      addr = a;
   endtask : gated
   task automatic power_up(input logic [ADDR_W-1:0] mode);
      for (int i = 0; i < T_PAUSE; i++) cmd(4'h7, ~bank_select, ~addr, ~dq_in, 2'h3);
      set_mode(mode);
      repeat (8) begin
         cmd(4'h1, 2'h0, 12'h000, ~dq_in, 2'h0);
         idle(T_GAP);
      end
   endtask : power_up
endmodule : sdcb_host_model
`default_nettype wire

// File: testbench/sdram_command_burst_core_tb_top.sv
// Purpose: self-checking bench for the sdram command and burst core
// Assumes: cas latency 2 or 3, array answers the cycle after a read beat
// Notes:   expected beats are queued by the driver, popped by the monitor
`timescale 1ns/1ps
`default_nettype none
module sdram_command_burst_core_tb_top;
   import sdcb_pkg::*;
   localparam logic [3:0] C_RD = 4'h5, C_WR = 4'h4, C_NOP = 4'h7, C_STOP = 4'h6;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [DQ_W-1:0] mem_rdata = 16'h0000;
   wire logic cs_n, row_strobe_n, col_strobe_n, write_strobe_n, clk_gate;
   wire logic low_byte_mask, high_byte_mask, dq_oe_lo_q, dq_oe_hi_q;
   wire logic mem_rd_q, mem_wr_q, interleave_q, init_done_q;
   wire logic [BANK_W-1:0] bank_select, mem_bank_q;
   wire logic [ADDR_W-1:0] addr, mem_row_q;
   wire logic [DQ_W-1:0] dq_in, dq_out_q, mem_wdata_q;
   wire logic [COL_W-1:0] mem_col_q;
   wire logic [1:0] mem_wbe_q;
   wire logic [2:0] burst_len_code_q, cas_lat_q;
   wire logic [NBANK-1:0] bank_open_q;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [15:0] seed = 16'h99a3;
   logic [21:0] rd_q[$];
   logic [25:0] wr_q[$];
   logic [17:0] dq_q[$];
   initial forever #2 core_clk = ~core_clk;
   sdcb_host_model host (.core_clk(core_clk), .cs_n(cs_n), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n), .clk_gate(clk_gate),
      .bank_select(bank_select), .addr(addr), .low_byte_mask(low_byte_mask),
      .high_byte_mask(high_byte_mask), .dq_in(dq_in));
   sdcb_core dut (.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n), .clk_gate(clk_gate),
      .bank_select(bank_select), .addr(addr), .low_byte_mask(low_byte_mask),
      .high_byte_mask(high_byte_mask), .dq_in(dq_in), .dq_out_q(dq_out_q),
      .dq_oe_lo_q(dq_oe_lo_q), .dq_oe_hi_q(dq_oe_hi_q), .mem_rdata(mem_rdata),
      .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_bank_q(mem_bank_q),
      .mem_row_q(mem_row_q), .mem_col_q(mem_col_q), .mem_wdata_q(mem_wdata_q),
      .mem_wbe_q(mem_wbe_q), .burst_len_code_q(burst_len_code_q),
      .interleave_q(interleave_q), .cas_lat_q(cas_lat_q), .bank_open_q(bank_open_q),
      .init_done_q(init_done_q));
   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [15:0] pat(input logic [7:0] c);
      return {~c, c};
   endfunction : pat
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask : check
   // mbeat marks the one beat whose low byte is masked, -1 for none
   task automatic exp_rd(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c0,
                         input int n, input logic [7:0] msk, input logic il, input int mbeat);
      logic [7:0] c;
      for (int k = 0; k < n; k++) begin
         c = il ? (c0 ^ k[7:0]) : ((c0 & ~msk) | ((c0 + k[7:0]) & msk));
         rd_q.push_back({b, r, c});
         dq_q.push_back({(k == mbeat) ? 2'b10 : 2'b11, pat(c)});
      end
   endtask : exp_rd
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // ***************************************************************
   // array model, monitor and timeout
   // ***************************************************************
   always @(posedge core_clk) begin
      if (mem_rd_q === 1'b1) mem_rdata <= #1 pat(mem_col_q);
      else mem_rdata <= #1 ~mem_rdata;
   end
   always @(posedge core_clk) begin
      logic [17:0] e;
      if (mem_rd_q === 1'b1) begin
         if (rd_q.size() == 0) check(1'b0, "unexpected read beat");
         else check({mem_bank_q, mem_row_q, mem_col_q} === rd_q.pop_front(), "read beat");
      end
      if (mem_wr_q === 1'b1) begin
         if (wr_q.size() == 0) check(1'b0, "unexpected write beat");
         else check({mem_col_q, mem_wdata_q, mem_wbe_q} === wr_q.pop_front(), "write beat");
      end
      if ({dq_oe_hi_q, dq_oe_lo_q} !== 2'b00) begin
         if (dq_q.size() == 0) check(1'b0, "unexpected data drive");
         else begin
            e = dq_q.pop_front();
            check({dq_oe_hi_q, dq_oe_lo_q} === e[17:16] && ((dq_out_q ^ e[15:0]) &
                  {{8{e[17]}}, {8{e[16]}}}) === 16'h0000, "read data");
         end
      end
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t timeout", $time);
         tally_and_finish();
      end
   end
   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      logic [15:0] d[6];
      repeat (3) @(posedge core_clk);
      check(burst_len_code_q === BL_RST && cas_lat_q === CL_RST && init_done_q === 1'b0
            && bank_open_q === 4'h0, "reset values");
      #1 nrst = 1'b1;
      host.power_up(12'h022);
      host.idle(2);
      check(init_done_q === 1'b1 && burst_len_code_q === BL_4 && cas_lat_q === CL_2
            && interleave_q === 1'b0, "mode after init");
      host.activate(2'h1, 12'h5a5);
      host.activate(2'h2, 12'h3c3);
      check(bank_open_q === 4'h6, "banks open");
      $display("test init done");
      // wrap at column ff, deselected read and closed bank both ignored
      exp_rd(2'h1, 12'h5a5, 8'hfe, 4, MASK_4, 1'b0, 1);
      host.cmd(C_RD, 2'h1, 12'h0fe, ~dq_in, 2'h0);
      host.cmd(4'hd, 2'h1, 12'h010, ~dq_in, 2'h1);
      host.idle(12);
      host.cmd(C_RD, 2'h3, 12'h030, ~dq_in, 2'h0);
      host.gated(C_RD, 2'h1, 12'h070);
      host.idle(12);
      $display("test read wrap done");
      exp_rd(2'h1, 12'h5a5, 8'h10, 1, MASK_4, 1'b0, -1);
      exp_rd(2'h2, 12'h3c3, 8'h20, 4, MASK_4, 1'b0, -1);
      host.cmd(C_RD, 2'h1, 12'h010, ~dq_in, 2'h0);
      host.cmd(C_RD, 2'h2, 12'h020, ~dq_in, 2'h0);
      host.idle(12);
      $display("test read interrupt done");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         d[i] = seed;
      end
      wr_q.push_back({8'h32, d[0], 2'b11});
      wr_q.push_back({8'h33, d[1], 2'b01});
      wr_q.push_back({8'h40, d[2], 2'b11});
      wr_q.push_back({8'h41, d[3], 2'b11});
      exp_rd(2'h1, 12'h5a5, 8'h44, 4, MASK_4, 1'b0, -1);
      host.cmd(C_WR, 2'h1, 12'h032, d[0], 2'h0);
      host.cmd(C_NOP, 2'h0, 12'h000, d[1], 2'h2);
      host.cmd(C_WR, 2'h1, 12'h040, d[2], 2'h0);
      host.cmd(C_NOP, 2'h0, 12'h000, d[3], 2'h0);
      host.cmd(C_RD, 2'h1, 12'h044, d[4], 2'h0);
      host.cmd(C_NOP, 2'h0, 12'h000, d[5], 2'h0);
      host.idle(12);
      $display("test write interrupt done");
      // masks float the two read beats that would meet the write data
      rd_q.push_back({2'h1, 12'h5a5, 8'h50});
      rd_q.push_back({2'h1, 12'h5a5, 8'h51});
      for (int i = 0; i < 4; i++) wr_q.push_back({8'h60 + i[7:0], d[i], 2'b11});
      host.cmd(C_RD, 2'h1, 12'h050, ~dq_in, 2'h3);
      host.cmd(C_NOP, 2'h0, 12'h000, ~dq_in, 2'h3);
      host.cmd(C_WR, 2'h1, 12'h060, d[0], 2'h0);
      for (int i = 1; i < 4; i++) host.cmd(C_NOP, 2'h0, 12'h000, d[i], 2'h0);
      host.idle(12);
      $display("test read cut by write done");
      host.set_mode(12'h03b);
      check(interleave_q === 1'b1 && burst_len_code_q === BL_8 && cas_lat_q === CL_3
            && bank_open_q === 4'h0, "interleave mode");
      host.activate(2'h1, 12'h5a5);
      exp_rd(2'h1, 12'h5a5, 8'h05, 8, MASK_8, 1'b1, -1);
      host.cmd(C_RD, 2'h1, 12'h005, ~dq_in, 2'h0);
      host.idle(16);
      $display("test interleave done");
      host.set_mode(12'h027);
      host.activate(2'h1, 12'h5a5);
      exp_rd(2'h1, 12'h5a5, 8'hfe, 3, MASK_PAGE, 1'b0, -1);
      host.cmd(C_RD, 2'h1, 12'h0fe, ~dq_in, 2'h0);
      host.idle(2);
      host.cmd(C_STOP, 2'h0, 12'h000, ~dq_in, 2'h0);
      host.idle(14);
      check(bank_open_q === 4'h2, "bank open after stop");
      check(rd_q.size() == 0 && wr_q.size() == 0 && dq_q.size() == 0, "beats left");
      $display("test burst stop done");
      tally_and_finish();
   end
endmodule : sdram_command_burst_core_tb_top
`default_nettype wire
